// ### rtl/imc_consts.svh
`ifndef IMC_CONSTS_SVH
`define IMC_CONSTS_SVH
// register offsets (byte addresses)
`define INT_MODE_CTL7_OFFSET 32'hFFFFE01C
`define IMC_STATUS_OFFSET 32'hFFFFE100
`define IMC_MASK_OFFSET 32'hFFFFE104
`define IMC_EDGE_STATUS_OFFSET 32'hFFFFE108
// lane layout
`define LANE_COUNT 3
`define LANE_WIDTH 8
`define LANE_FIELD_LSB 0
`define LANE_FIELD_MSB 2
`define LANE_DMA_BIT 4
`define LANE_ACT_LSB 5
`define LANE_ACT_MSB 6
// masks and reset values
`define LANE_WRITE_MASK 8'h77
`define INT_MODE_CTL7_RESET 32'h00000000
`define ACT_RISING_EDGE 2'h3
`define LEVEL_DISABLED 3'h0
`define IRQ_STATUS_RESET 3'h0
`define IRQ_MASK_RESET 3'h0
`endif

// ### rtl/imc_pkg.sv
package imc_pkg;
  // one lane of the mode control register
  typedef struct packed {
    logic spare_hi;
    logic [1:0] active_state;
    logic dma_trigger_sel;
    logic spare_lo;
    logic [2:0] level_or_channel;
  } lane_cfg_t;

  // register port request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // routed request toward resolver and dma controller
  typedef struct packed {
    logic irq_valid;
    logic [2:0] irq_level;
    logic dma_valid;
    logic [2:0] dma_channel;
  } lane_route_t;
endpackage : imc_pkg

// ### rtl/imc_lane.sv
`include "imc_consts.svh"
// per-lane edge detection and routing to priority resolver or dma
module imc_lane
  import imc_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input imc_pkg::lane_cfg_t cfg, // lane configuration
  input wire logic src_level, // synchronised source level
  output imc_pkg::lane_route_t route, // routed one-cycle request
  output logic edge_seen // rising edge pulse
);
  logic prev_q;
  logic prev_d;
  logic rise;
  // remember previous level
  always_comb
  begin
    prev_d = src_level;
  end
  always_ff @(posedge clock)
  begin
    if (rst)
      prev_q <= 1'b0;
    else
      prev_q <= prev_d;
  end
  // rising edge only when active state is 11
  assign rise = src_level & ~prev_q & (cfg.active_state == `ACT_RISING_EDGE);
  assign edge_seen = rise;
  // dma bit chooses role; field is level or channel
  always_comb
  begin
    route = '0;
    if (cfg.dma_trigger_sel)
    begin
      route.dma_valid = rise;
      route.dma_channel = cfg.level_or_channel;
    end
    else
    begin
      route.irq_valid = rise & (cfg.level_or_channel != `LEVEL_DISABLED);
      route.irq_level = cfg.level_or_channel;
    end
  end
endmodule : imc_lane

// ### rtl/interrupt_mode_control_lanes.sv
// Notes on behaviour
// - each lane's active-state field must be 11; sources then act on rising edge
// - dma-trigger bit 1 makes source 28, 29 or 30 a dma cause, 0 not
// - dma bit 0: field is priority level, 000 disables, 001-111 levels 1-7; here 000 blocks only edge_irq_valid, the edge still sets status and irq
// - dma bit 1: field picks dma channel 0 to 7
// - bits 7:0 source 28, 15:8 source 29, 23:16 source 30
//
// Added by the designer: the address-and-strobe port.
`include "imc_consts.svh"
module interrupt_mode_control_lanes
  import imc_pkg::*;
(
  input wire logic clock, // 125 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [31:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic capture0_irq, // source 28 raw request
  input wire logic compare0_irq, // source 29 raw request
  input wire logic compare_match1_irq, // source 30 raw request
  output logic [31:0] rdata, // read data, cycle after rd
  output logic [8:0] irq_req, // lane n priority level at [3n+2:3n]
  output logic [11:0] dma_req, // per lane {valid,channel[2:0]} x3
  output logic [2:0] edge_irq_valid, // per lane priority request pulse
  output logic irq // summary interrupt level
);
  import imc_pkg::*;

  logic [31:0] mode_ctl7_q;
  logic [31:0] mode_ctl7_d;
  logic [2:0] status_q;
  logic [2:0] status_d;
  logic [2:0] mask_q;
  logic [2:0] mask_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] stable_q;
  logic [2:0] stable_d;
  logic [2:0] raw_src;
  logic [2:0] edge_seen;
  logic [8:0] irq_req_d;
  logic [8:0] irq_req_q;
  logic [11:0] dma_req_d;
  logic [11:0] dma_req_q;
  logic [2:0] ivalid_d;
  logic [2:0] ivalid_q;
  logic irq_q;
  logic irq_d;
  lane_route_t route [`LANE_COUNT];

  assign raw_src = {compare_match1_irq, compare0_irq, capture0_irq};

  // three-flop synchroniser; change accepted when stages two and three agree
  always_comb
  begin
    stable_d = stable_q;
    for (int i = 0; i < `LANE_COUNT; i++)
    begin
      if (sync2_q[i] == sync3_q[i])
        stable_d[i] = sync3_q[i];
    end
  end
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      stable_q <= 3'h0;
    end
    else
    begin
      sync1_q <= raw_src;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      stable_q <= stable_d;
    end
  end

  // lanes: source 28 at bits 7:0, 29 at 15:8, 30 at 23:16
  for (genvar g = 0; g < `LANE_COUNT; g++)
  begin : g_lane
    imc_lane u_lane (
      .clock(clock),
      .rst(rst),
      .cfg(lane_cfg_t'(mode_ctl7_q[g*`LANE_WIDTH +: `LANE_WIDTH])),
      .src_level(stable_q[g]),
      .route(route[g]),
      .edge_seen(edge_seen[g])
    );
    assign irq_req_d[g*3 +: 3] = route[g].irq_level;
    assign dma_req_d[g*4 +: 4] = {route[g].dma_valid, route[g].dma_channel};
    assign ivalid_d[g] = route[g].irq_valid;

    // dma lane never raises a priority request
    a_lane_dma_role: assert property (@(posedge clock) disable iff (rst)
      mode_ctl7_q[g*`LANE_WIDTH + `LANE_DMA_BIT] |=> !ivalid_q[g]) else $error("dma lane raised priority request");
    // recognised edge in dma role becomes a dma request
    a_lane_dma_cause: assert property (@(posedge clock) disable iff (rst)
      (edge_seen[g] && mode_ctl7_q[g*`LANE_WIDTH + `LANE_DMA_BIT]) |=> dma_req_q[g*4 + 3])
      else $error("dma request lost");
    // dma request carries the lane field as channel
    a_lane_dma_map: assert property (@(posedge clock) disable iff (rst)
      dma_req_q[g*4 + 3] |-> dma_req_q[g*4 +: 3] == $past(mode_ctl7_q[g*`LANE_WIDTH +: 3]))
      else $error("dma channel differs from field");
    // priority request only with a non-zero level
    a_lane_level: assert property (@(posedge clock) disable iff (rst)
      ivalid_q[g] |-> irq_req_q[g*3 +: 3] != 3'h0) else $error("priority request at level zero");
    // edge accepted only in rising-edge mode
    a_lane_mode: assert property (@(posedge clock) disable iff (rst)
      edge_seen[g] |-> mode_ctl7_q[g*`LANE_WIDTH + `LANE_ACT_LSB +: 2] == `ACT_RISING_EDGE)
      else $error("edge taken outside rising-edge mode");
  end

  // register writes, sticky status (set wins over clear), mask
  always_comb
  begin
    mode_ctl7_d = mode_ctl7_q;
    mask_d = mask_q;
    status_d = status_q;
    if (wr && addr == `INT_MODE_CTL7_OFFSET)
      mode_ctl7_d = wdata & {8'h00, {`LANE_COUNT{`LANE_WRITE_MASK}}};
    if (wr && addr == `IMC_MASK_OFFSET)
      mask_d = wdata[2:0];
    if (wr && addr == `IMC_STATUS_OFFSET)
      status_d = status_q & ~wdata[2:0];
    status_d = status_d | edge_seen;
  end

  // read mux, unmapped reads zero
  always_comb
  begin
    rdata_d = 32'h00000000;
    if (rd)
    begin
      case (addr)
        `INT_MODE_CTL7_OFFSET: rdata_d = mode_ctl7_q;
        `IMC_STATUS_OFFSET: rdata_d = {29'h0, status_q};
        `IMC_MASK_OFFSET: rdata_d = {29'h0, mask_q};
        `IMC_EDGE_STATUS_OFFSET: rdata_d = {29'h0, stable_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // summary interrupt
  always_comb
  begin
    irq_d = |(status_d & mask_d);
  end

  // configuration, status and mask registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mode_ctl7_q <= `INT_MODE_CTL7_RESET;
      status_q <= `IRQ_STATUS_RESET;
      mask_q <= `IRQ_MASK_RESET;
    end
    else
    begin
      mode_ctl7_q <= mode_ctl7_d;
      status_q <= status_d;
      mask_q <= mask_d;
    end
  end

  // registered outputs
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdata_q <= 32'h00000000;
      irq_req_q <= 9'h000;
      dma_req_q <= 12'h000;
      ivalid_q <= 3'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      irq_req_q <= irq_req_d;
      dma_req_q <= dma_req_d;
      ivalid_q <= ivalid_d;
      irq_q <= irq_d;
    end
  end

  assign rdata = rdata_q;
  assign irq_req = irq_req_q;
  assign dma_req = dma_req_q;
  assign edge_irq_valid = ivalid_q;
  assign irq = irq_q;

  // reserved bits never set
  a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
    (mode_ctl7_q & 32'hFF888888) == 32'h00000000) else $error("reserved bits set");
  // write reaches register next cycle with mask applied
  a_write_lands: assert property (@(posedge clock) disable iff (rst)
    (wr && addr == `INT_MODE_CTL7_OFFSET) |=> mode_ctl7_q == ($past(wdata) & 32'h00777777))
    else $error("write lost");
  // dma lane never raises priority request
  a_dma_no_irq: assert property (@(posedge clock) disable iff (rst)
    (mode_ctl7_q[4] && $stable(mode_ctl7_q)) |=> !ivalid_q[0]) else $error("dma lane raised irq");
  // level zero never requests
  a_level_zero: assert property (@(posedge clock) disable iff (rst)
    (mode_ctl7_q[4] == 1'b0 && mode_ctl7_q[2:0] == 3'h0) |=> !ivalid_q[0]) else $error("disabled level fired");
  // dma channel follows field
  a_dma_channel: assert property (@(posedge clock) disable iff (rst)
    dma_req_d[3] |=> dma_req_q[2:0] == $past(mode_ctl7_q[2:0])) else $error("wrong dma channel");
  // edge needs state 11
  a_edge_mode: assert property (@(posedge clock) disable iff (rst)
    edge_seen[0] |-> mode_ctl7_q[6:5] == 2'h3 && stable_q[0]) else $error("edge without mode 11");
  // read data one cycle after strobe
  a_read_imc: assert property (@(posedge clock) disable iff (rst)
    (rd && addr == `INT_MODE_CTL7_OFFSET) |=> rdata == $past(mode_ctl7_q)) else $error("bad read");
  // reset clears register
  a_reset_zero: assert property (@(posedge clock)
    rst |=> mode_ctl7_q == 32'h00000000) else $error("reset value wrong");
  // filtered level changes only after stages two and three agree
  a_sync_agree: assert property (@(posedge clock) disable iff (rst)
    $changed(stable_q[0]) |-> $past(sync2_q[0] == sync3_q[0])) else $error("filtered level changed early");
  // recognised edge is recorded in status
  a_status_set: assert property (@(posedge clock) disable iff (rst)
    edge_seen[0] |=> status_q[0]) else $error("edge not recorded");
endmodule : interrupt_mode_control_lanes

// ### testbench/src_model.sv
module src_model (
  input wire logic clock, // system clock
  input wire logic [2:0] go, // start one request per source
  output logic [2:0] src // raw source levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q [3] = '{default: 3'h0};
  // high four cycles, then low long enough to re-arm the edge
  always @(posedge clock)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (go[i])
        cnt_q[i] <= 3'h4;
      else if (cnt_q[i] != 3'h0)
        cnt_q[i] <= cnt_q[i] - 3'h1;
    end
  end
  // level follows the hold counter
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      src[i] = (cnt_q[i] != 3'h0);
  end
endmodule : src_model

// ### testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] go = 3'h0;
  logic [2:0] src;
  logic [31:0] rdata;
  logic [8:0] irq_req;
  logic [11:0] dma_req;
  logic [2:0] edge_irq_valid;
  logic irq;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;
  interrupt_mode_control_lanes dut_u (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .capture0_irq(src[0]), .compare0_irq(src[1]), .compare_match1_irq(src[2]), .rdata(rdata),
    .irq_req(irq_req), .dma_req(dma_req), .edge_irq_valid(edge_irq_valid), .irq(irq));
  src_model src_u (.clock(clock), .go(go), .src(src));
  // clock and hang guard
  initial
  begin
    forever #4 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input string what, input logic [31:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(what, exp, rdata);
  endtask : rd_reg
  // configure, fire all sources, collect pulses, then clear status
  task automatic run(input logic [31:0] cfg, input logic [2:0] e_irq, input logic [11:0] e_dma,
    input logic [2:0] e_stat, input logic [8:0] e_lvl);
    logic [2:0] seen_irq;
    logic [11:0] seen_dma;
    seen_irq = 3'h0;
    seen_dma = 12'h0;
    wr_reg(32'hFFFFE01C, cfg);
    @(posedge clock);
    go <= 3'h7;
    @(posedge clock);
    go <= 3'h0;
    repeat (20)
    begin
      @(posedge clock);
      #1;
      seen_irq = seen_irq | edge_irq_valid;
      for (int i = 0; i < 3; i++)
        if (dma_req[4 * i + 3] === 1'b1) seen_dma[4 * i +: 4] = dma_req[4 * i +: 4];
    end
    check("edge_irq_valid", {29'h0, e_irq}, {29'h0, seen_irq});
    check("dma_req", {20'h0, e_dma}, {20'h0, seen_dma});
    check("irq_req", {23'h0, e_lvl}, {23'h0, irq_req});
    rd_reg("status", 32'hFFFFE100, {29'h0, e_stat});
    check("irq", 32'h1, {31'h0, irq});
    wr_reg(32'hFFFFE100, 32'h7);
    repeat (3) @(posedge clock);
    #1;
    check("irq cleared", 32'h0, {31'h0, irq});
  endtask : run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd_reg("reset value", 32'hFFFFE01C, 32'h0);
    wr_reg(32'hFFFFE01C, 32'hFFFFFFFF);
    rd_reg("reserved bits", 32'hFFFFE01C, 32'h00777777);
    rd_reg("unmapped", 32'hFFFFE000, 32'h0);
    wr_reg(32'hFFFFE104, 32'h7);
    rd_reg("mask", 32'hFFFFE104, 32'h7);
    rd_reg("source levels", 32'hFFFFE108, 32'h0);
    run(32'h00037665, 3'h1, 12'h0E0, 3'h3, 9'h0C5);
    run(32'h00730060, 3'h0, 12'hB00, 3'h5, 9'h000);
    end_of_test();
  end
endmodule : testbench
